// ==== design/radio_packet_handler.sv ====
// packet framing, filtering and status engine of the radio
`timescale 1ns/1ps
`default_nettype none
module radio_packet_handler #(
	parameter int DEPTH = rph_pkg::FIFO_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic [1:0]    length_mode,
	input  wire logic [7:0]    packet_length_setting,
	input  wire logic [1:0]    address_filter_mode,
	input  wire logic [7:0]    node_address,
	input  wire logic          crc_enable,
	input  wire logic          crc_fail_flush_enable,
	input  wire logic          status_append_enable,
	input  wire logic [3:0]    preamble_count,
	input  wire logic          sync_double,
	input  wire logic [15:0]   sync_word,
	input  wire logic [1:0]    receive_exit_state,
	input  wire logic [1:0]    transmit_exit_state,
	input  wire logic [5:0]    output_pin_function_zero,
	input  wire logic [5:0]    output_pin_function_two,
	input  wire logic [CW-1:0] fifo_threshold,
	input  wire logic          tx_strobe,
	input  wire logic          rx_strobe,
	input  wire logic          idle_strobe,
	input  wire logic          transmit_fifo_flush_strobe,
	input  wire logic [7:0]    tx_fifo_data,
	input  wire logic [CW-1:0] transmit_fill_count,
	input  wire logic [CW-1:0] receive_fill_count,
	input  wire logic          tx_byte_ready,
	input  wire logic          rx_sync_found,
	input  wire logic [7:0]    rx_byte_in,
	input  wire logic          rx_byte_valid,
	input  wire logic [7:0]    rssi_value,
	output logic               tx_fifo_pop,
	output logic [7:0]         tx_byte,
	output logic               tx_byte_valid,
	output logic               rx_fifo_write,
	output logic [7:0]         rx_fifo_data,
	output logic               rx_fifo_drop,
	output logic               rx_fifo_flush,
	output logic               general_output_zero,
	output logic               general_output_two,
	output logic [7:0]         packet_state_flags,
	output logic [7:0]         chip_status,
	output logic [2:0]         radio_state,
	output logic               packet_done
);
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ rph_pkg::CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic rph_pkg::rph_state_t exit_target(input logic [1:0] code);
		case (code)
			rph_pkg::EXIT_TX: return rph_pkg::RPH_TX_PRE;
			rph_pkg::EXIT_RX: return rph_pkg::RPH_RX_SEARCH;
			default: return rph_pkg::RPH_IDLE;
		endcase
	endfunction

	function automatic logic [2:0] state_code(input rph_pkg::rph_state_t s);
		case (s)
			rph_pkg::RPH_IDLE: return rph_pkg::RS_IDLE;
			rph_pkg::RPH_TX_UFLOW: return rph_pkg::RS_UFLOW;
			rph_pkg::RPH_RX_SEARCH, rph_pkg::RPH_RX_DATA, rph_pkg::RPH_RX_CRC,
			rph_pkg::RPH_RX_TAIL, rph_pkg::RPH_RX_STAT2: return rph_pkg::RS_RX;
			default: return rph_pkg::RS_TX;
		endcase
	endfunction

	rph_pkg::rph_state_t state, next_state;
	logic [7:0]  byte_count, next_byte_count;
	logic [7:0]  var_len, next_var_len;
	logic [3:0]  pre_count, next_pre_count;
	logic [1:0]  sub_idx, next_sub_idx;
	logic        first, next_first;
	logic        addr_pending, next_addr_pending;
	logic [15:0] crc, next_crc;
	logic        crc_ok, next_crc_ok;
	logic        hold_pending, next_hold_pending;
	logic [7:0]  hold_data, next_hold_data;
	logic        sync_active, next_sync_active;
	logic        next_tx_fifo_pop, next_tx_byte_valid, next_rx_fifo_write;
	logic [7:0]  next_tx_byte, next_rx_fifo_data;
	logic        next_rx_fifo_drop, next_rx_fifo_flush, next_packet_done;
	logic        next_general_output_zero, next_general_output_two;
	logic        need_tx, addr_match, pkt_end;
	logic [7:0]  count_inc, crc_in;
	logic [CW-1:0] shown_count;

	// pin function decode shared by both output pins
	function automatic logic pin_level(input logic [5:0] fn, input logic in_pkt, input logic [CW-1:0] rxc,
			input logic [CW-1:0] txc, input logic [CW-1:0] thr);
		case (fn)
			rph_pkg::FN_RX_THR: return rxc >= thr;
			rph_pkg::FN_RX_THR_END: return (rxc >= thr) || (!in_pkt && rxc != '0);
			rph_pkg::FN_TX_THR: return txc >= thr;
			rph_pkg::FN_TX_FULL: return txc == CW'(DEPTH);
			rph_pkg::FN_SYNC: return in_pkt;
			default: return 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// a new byte slot opens once the modem took the last; wait out a pending pop
	assign need_tx = (!tx_byte_valid || tx_byte_ready) && !tx_fifo_pop;
	assign count_inc = byte_count + 8'h01;
	assign crc_in = (state == rph_pkg::RPH_RX_DATA || state == rph_pkg::RPH_RX_CRC) ? rx_byte_in : tx_fifo_data;
	assign addr_match = (rx_byte_in == node_address)
		|| (address_filter_mode == rph_pkg::ADDR_BCAST0 && rx_byte_in == rph_pkg::BCAST_LOW)
		|| (address_filter_mode == rph_pkg::ADDR_BCAST_BOTH
			&& (rx_byte_in == rph_pkg::BCAST_LOW || rx_byte_in == rph_pkg::BCAST_HIGH));
	// live mode and length compared every byte
	assign pkt_end = (length_mode == rph_pkg::LEN_FIXED && count_inc == packet_length_setting)
		|| (length_mode == rph_pkg::LEN_VARIABLE && count_inc == var_len);
	assign shown_count = (state_code(state) == rph_pkg::RS_RX) ? receive_fill_count : transmit_fill_count;

	always_comb begin
		next_state = state;
		next_byte_count = byte_count;
		next_var_len = var_len;
		next_pre_count = pre_count;
		next_sub_idx = sub_idx;
		next_first = first;
		next_addr_pending = addr_pending;
		next_crc = crc;
		next_crc_ok = crc_ok;
		next_hold_pending = 1'b0;
		next_hold_data = hold_data;
		next_sync_active = sync_active;
		next_tx_fifo_pop = 1'b0;
		next_tx_byte = tx_byte;
		next_tx_byte_valid = tx_byte_valid && !tx_byte_ready;
		next_rx_fifo_write = 1'b0;
		next_rx_fifo_data = rx_fifo_data;
		next_rx_fifo_drop = 1'b0;
		next_rx_fifo_flush = 1'b0;
		next_packet_done = 1'b0;
		if (hold_pending) begin
			next_rx_fifo_write = 1'b1;
			next_rx_fifo_data = hold_data;
		end
		case (state)
			rph_pkg::RPH_IDLE: begin
				if (tx_strobe) begin
					next_state = rph_pkg::RPH_TX_PRE;
				end else if (rx_strobe) begin
					next_state = rph_pkg::RPH_RX_SEARCH;
				end
			end
			// preamble until count met and fifo holds data
			rph_pkg::RPH_TX_PRE: begin
				next_byte_count = 8'h00;
				next_first = 1'b1;
				next_crc = rph_pkg::CRC_INIT;
				if (need_tx) begin
					next_tx_byte_valid = 1'b1;
					if (pre_count >= preamble_count && transmit_fill_count != '0) begin
						next_tx_byte = sync_word[15:8];
						next_sub_idx = 2'd1;
						next_sync_active = 1'b1;
						next_state = rph_pkg::RPH_TX_SYNC;
					end else begin
						next_tx_byte = rph_pkg::PREAMBLE_BYTE;
						next_pre_count = (pre_count == 4'hF) ? pre_count : pre_count + 4'h1;
					end
				end
			end
			rph_pkg::RPH_TX_SYNC: begin
				if (need_tx) begin
					next_tx_byte_valid = 1'b1;
					next_tx_byte = sub_idx[0] ? sync_word[7:0] : sync_word[15:8];
					next_sub_idx = sub_idx + 2'd1;
					if (sub_idx == (sync_double ? 2'd3 : 2'd1)) begin
						next_state = rph_pkg::RPH_TX_DATA;
					end
				end
			end
			rph_pkg::RPH_TX_DATA: begin
				if (need_tx) begin
					if (transmit_fill_count == '0) begin
						next_state = rph_pkg::RPH_TX_UFLOW;
						next_sync_active = 1'b0;
					end else begin
						next_tx_fifo_pop = 1'b1;
						next_tx_byte_valid = 1'b1;
						next_tx_byte = tx_fifo_data;
						next_crc = crc_step(crc, crc_in);
						next_first = 1'b0;
						next_sub_idx = 2'd0;
						if (first && length_mode == rph_pkg::LEN_VARIABLE) begin
							next_var_len = tx_fifo_data;
							if (tx_fifo_data == 8'h00) begin
								next_state = crc_enable ? rph_pkg::RPH_TX_CRC : rph_pkg::RPH_TX_END;
							end
						end else begin
							next_byte_count = count_inc;
							if (pkt_end) begin
								next_state = crc_enable ? rph_pkg::RPH_TX_CRC : rph_pkg::RPH_TX_END;
							end
						end
					end
				end
			end
			rph_pkg::RPH_TX_CRC: begin
				if (need_tx) begin
					next_tx_byte_valid = 1'b1;
					next_tx_byte = sub_idx[0] ? crc[7:0] : crc[15:8];
					next_sub_idx = sub_idx + 2'd1;
					if (sub_idx[0]) begin
						next_state = rph_pkg::RPH_TX_END;
					end
				end
			end
			// exit once the last byte is taken
			rph_pkg::RPH_TX_END: begin
				if (need_tx) begin
					next_state = exit_target(transmit_exit_state);
					next_packet_done = 1'b1;
					next_sync_active = 1'b0;
				end
			end
			rph_pkg::RPH_TX_UFLOW: begin
				next_tx_byte_valid = 1'b0;
				if (transmit_fifo_flush_strobe) begin
					next_state = rph_pkg::RPH_IDLE;
				end
			end
			rph_pkg::RPH_RX_SEARCH: begin
				next_byte_count = 8'h00;
				next_first = 1'b1;
				next_addr_pending = address_filter_mode != rph_pkg::ADDR_OFF;
				next_crc = rph_pkg::CRC_INIT;
				next_crc_ok = 1'b1;
				next_sub_idx = 2'd0;
				if (rx_sync_found) begin
					next_sync_active = 1'b1;
					next_state = rph_pkg::RPH_RX_DATA;
				end
			end
			rph_pkg::RPH_RX_DATA: begin
				if (rx_byte_valid) begin
					next_crc = crc_step(crc, crc_in);
					next_first = 1'b0;
					if (first && length_mode == rph_pkg::LEN_VARIABLE) begin
						next_var_len = rx_byte_in;
						if (rx_byte_in > packet_length_setting) begin
							next_state = rph_pkg::RPH_RX_SEARCH;
							next_sync_active = 1'b0;
						end else begin
							next_rx_fifo_write = 1'b1;
							next_rx_fifo_data = rx_byte_in;
							if (rx_byte_in == 8'h00) begin
								next_state = crc_enable ? rph_pkg::RPH_RX_CRC : rph_pkg::RPH_RX_TAIL;
							end
						end
					end else if (addr_pending && !addr_match) begin
						next_rx_fifo_drop = 1'b1;
						next_state = rph_pkg::RPH_RX_SEARCH;
						next_sync_active = 1'b0;
					end else begin
						next_addr_pending = 1'b0;
						next_rx_fifo_write = 1'b1;
						next_rx_fifo_data = rx_byte_in;
						// marker byte ahead of the address
						if (addr_pending && length_mode == rph_pkg::LEN_INFINITE) begin
							next_rx_fifo_data = rph_pkg::INF_ADDR_MARK;
							next_hold_pending = 1'b1;
							next_hold_data = rx_byte_in;
						end
						next_byte_count = count_inc;
						if (pkt_end) begin
							next_state = crc_enable ? rph_pkg::RPH_RX_CRC : rph_pkg::RPH_RX_TAIL;
						end
					end
				end
			end
			rph_pkg::RPH_RX_CRC: begin
				if (rx_byte_valid) begin
					next_crc = crc_step(crc, crc_in);
					next_sub_idx = sub_idx + 2'd1;
					if (sub_idx[0]) begin
						next_crc_ok = next_crc == 16'h0000;
						next_state = rph_pkg::RPH_RX_TAIL;
					end
				end
			end
			rph_pkg::RPH_RX_TAIL: begin
				if (!hold_pending) begin
					// flush whole fifo on bad crc
					if (!crc_ok && crc_fail_flush_enable) begin
						next_rx_fifo_flush = 1'b1;
						next_state = exit_target(receive_exit_state);
						next_packet_done = 1'b1;
						next_sync_active = 1'b0;
					// first status byte is signal strength
					end else if (status_append_enable) begin
						next_rx_fifo_write = 1'b1;
						next_rx_fifo_data = rssi_value;
						next_state = rph_pkg::RPH_RX_STAT2;
					end else begin
						next_state = exit_target(receive_exit_state);
						next_packet_done = 1'b1;
						next_sync_active = 1'b0;
					end
				end
			end
			// crc flag in bit 7, rest zero
			rph_pkg::RPH_RX_STAT2: begin
				next_rx_fifo_write = 1'b1;
				next_rx_fifo_data = 8'h00;
				next_rx_fifo_data[rph_pkg::CRC_OK_BIT] = crc_ok;
				next_state = exit_target(receive_exit_state);
				next_packet_done = 1'b1;
				next_sync_active = 1'b0;
			end
			default: next_state = rph_pkg::RPH_IDLE;
		endcase
		if (state == rph_pkg::RPH_IDLE || (state_code(next_state) == rph_pkg::RS_TX
				&& state_code(state) != rph_pkg::RS_TX)) begin
			next_pre_count = 4'h0;
		end
		// idle ends infinite packets; never escapes the drain error
		if (idle_strobe && state != rph_pkg::RPH_TX_UFLOW) begin
			next_state = rph_pkg::RPH_IDLE;
			// byte not sent stays in the fifo
			next_tx_fifo_pop = 1'b0;
			next_sync_active = 1'b0;
			next_tx_byte_valid = 1'b0;
		end
		next_general_output_zero = pin_level(output_pin_function_zero, sync_active, receive_fill_count, transmit_fill_count,
			fifo_threshold);
		next_general_output_two = pin_level(output_pin_function_two, sync_active, receive_fill_count, transmit_fill_count,
			fifo_threshold);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= rph_pkg::RPH_IDLE;
			{byte_count, var_len, pre_count, sub_idx, first, addr_pending} <= '0;
			{crc, crc_ok, hold_pending, hold_data, sync_active} <= '0;
			{tx_fifo_pop, tx_byte, tx_byte_valid, rx_fifo_write, rx_fifo_data} <= '0;
			{rx_fifo_drop, rx_fifo_flush, packet_done, general_output_zero, general_output_two} <= '0;
			{packet_state_flags, chip_status, radio_state} <= '0;
		end else begin
			state <= next_state;
			byte_count <= next_byte_count;
			var_len <= next_var_len;
			pre_count <= next_pre_count;
			sub_idx <= next_sub_idx;
			first <= next_first;
			addr_pending <= next_addr_pending;
			crc <= next_crc;
			crc_ok <= next_crc_ok;
			hold_pending <= next_hold_pending;
			hold_data <= next_hold_data;
			sync_active <= next_sync_active;
			tx_fifo_pop <= next_tx_fifo_pop;
			tx_byte <= next_tx_byte;
			tx_byte_valid <= next_tx_byte_valid;
			rx_fifo_write <= next_rx_fifo_write;
			rx_fifo_data <= next_rx_fifo_data;
			rx_fifo_drop <= next_rx_fifo_drop;
			rx_fifo_flush <= next_rx_fifo_flush;
			packet_done <= next_packet_done;
			general_output_zero <= next_general_output_zero;
			general_output_two <= next_general_output_two;
			// pin levels and fill count exposed
			packet_state_flags <= 8'(next_general_output_zero) << rph_pkg::FLAG_GENERAL_OUTPUT_ZERO_BIT
				| 8'(next_general_output_two) << rph_pkg::FLAG_GENERAL_OUTPUT_TWO_BIT | 8'(next_sync_active) << rph_pkg::FLAG_SYNC_BIT;
			chip_status <= {state_code(next_state), 1'b0,
				(shown_count > CW'(rph_pkg::STATUS_CNT_MAX)) ? rph_pkg::STATUS_CNT_MAX : 4'(shown_count)};
			radio_state <= state_code(next_state);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_count_wrap: assert property (($past(byte_count) == 8'hFF && byte_count != 8'hFF) |-> byte_count == 8'h00)
		else $error("byte counter did not wrap to zero");
	a_fixed_end: assert property (($past(state) == rph_pkg::RPH_RX_DATA && $changed(byte_count)
		&& $past(length_mode) == rph_pkg::LEN_FIXED && byte_count == $past(packet_length_setting)
		&& !$past(idle_strobe)) |-> state != rph_pkg::RPH_RX_DATA)
		else $error("fixed length reached but receive continued");
	a_addr_drop: assert property (rx_fifo_drop |-> state == rph_pkg::RPH_RX_SEARCH && !rx_fifo_write)
		else $error("address mismatch did not restart receive");
	a_len_reject: assert property (($past(state) == rph_pkg::RPH_RX_DATA && $past(rx_byte_valid) && $past(first)
		&& $past(length_mode) == rph_pkg::LEN_VARIABLE && $past(rx_byte_in) > $past(packet_length_setting))
		|-> !rx_fifo_write ##1 state == rph_pkg::RPH_RX_SEARCH || $past(idle_strobe, 2))
		else $error("oversize length byte not discarded");
	a_flush_exit: assert property (rx_fifo_flush |-> packet_done && !rx_fifo_write)
		else $error("flush without packet end");
	a_uflow_hold: assert property ((state == rph_pkg::RPH_TX_UFLOW && !transmit_fifo_flush_strobe)
		|=> state == rph_pkg::RPH_TX_UFLOW [*1] ##0 radio_state == rph_pkg::RS_UFLOW)
		else $error("drain error left without flush");
	a_stat2_byte: assert property (($past(state) == rph_pkg::RPH_RX_STAT2 && rx_fifo_write)
		|-> rx_fifo_data == {$past(crc_ok), 7'h00})
		else $error("second status byte wrong");
	a_preamble_byte: assert property ((state == rph_pkg::RPH_TX_PRE && tx_byte_valid)
		|-> tx_byte == rph_pkg::PREAMBLE_BYTE)
		else $error("preamble pattern wrong");
	a_gdo_sync: assert property ((output_pin_function_zero == rph_pkg::FN_SYNC)
		|=> general_output_zero == $past(sync_active))
		else $error("sync pin function not following packet");
	a_pop_data: assert property (tx_fifo_pop |-> tx_byte_valid && state != rph_pkg::RPH_TX_PRE
		##1 !tx_fifo_pop)
		else $error("fifo pop without data byte");

	c_tx_done: cover property (state == rph_pkg::RPH_TX_END ##1 packet_done);
	c_tx_uflow: cover property (state == rph_pkg::RPH_TX_DATA ##1 state == rph_pkg::RPH_TX_UFLOW);
	c_rx_drop: cover property (rx_fifo_drop);
	c_rx_flush: cover property (rx_fifo_flush);
endmodule
`default_nettype wire

// ==== design/rph_pkg.sv ====
// constants and types for the radio packet handler
package rph_pkg;
	localparam logic [1:0] LEN_FIXED = 2'h0;
	localparam logic [1:0] LEN_VARIABLE = 2'h1;
	localparam logic [1:0] LEN_INFINITE = 2'h2;
	localparam logic [1:0] ADDR_OFF = 2'h0;
	localparam logic [1:0] ADDR_BCAST0 = 2'h2;
	localparam logic [1:0] ADDR_BCAST_BOTH = 2'h3;
	localparam logic [7:0] BCAST_LOW = 8'h00;
	localparam logic [7:0] BCAST_HIGH = 8'hFF;
	localparam logic [7:0] INF_ADDR_MARK = 8'hFF;
	localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam int CRC_OK_BIT = 7;
	localparam logic [1:0] EXIT_TX = 2'h2;
	localparam logic [1:0] EXIT_RX = 2'h3;
	localparam logic [5:0] FN_RX_THR = 6'h00;
	localparam logic [5:0] FN_RX_THR_END = 6'h01;
	localparam logic [5:0] FN_TX_THR = 6'h02;
	localparam logic [5:0] FN_TX_FULL = 6'h03;
	localparam logic [5:0] FN_SYNC = 6'h06;
	localparam logic [2:0] RS_IDLE = 3'h0;
	localparam logic [2:0] RS_RX = 3'h1;
	localparam logic [2:0] RS_TX = 3'h2;
	localparam logic [2:0] RS_UFLOW = 3'h7;
	localparam int FLAG_GENERAL_OUTPUT_ZERO_BIT = 0;
	localparam int FLAG_GENERAL_OUTPUT_TWO_BIT = 2;
	localparam int FLAG_SYNC_BIT = 3;
	localparam logic [3:0] STATUS_CNT_MAX = 4'hF;
	localparam int FIFO_DEPTH = 64;

	typedef enum logic [3:0] {
		RPH_IDLE, RPH_TX_PRE, RPH_TX_SYNC, RPH_TX_DATA, RPH_TX_CRC, RPH_TX_END, RPH_TX_UFLOW,
		RPH_RX_SEARCH, RPH_RX_DATA, RPH_RX_CRC, RPH_RX_TAIL, RPH_RX_STAT2
	} rph_state_t;
endpackage

// ==== test/radio_packet_handler_tb.sv ====
// self-checking bench for the radio packet handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("Error at %0t: %h vs %h", $time, a, e); end end
module radio_packet_handler_tb;
	logic clock = 0, rst_n = 0, crc_enable = 0, crc_fail_flush_enable = 0, status_append_enable = 0;
	logic sync_double = 0, tx_strobe = 0, rx_strobe = 0, idle_strobe = 0, transmit_fifo_flush_strobe = 0;
	logic rx_sync_found = 0, rx_byte_valid = 0, stall = 0;
	logic [1:0] length_mode = 0, address_filter_mode = 0, receive_exit_state = 0, transmit_exit_state = 0;
	logic [3:0] preamble_count = 4'h1;
	logic [5:0] output_pin_function_zero = rph_pkg::FN_SYNC, output_pin_function_two = rph_pkg::FN_TX_THR;
	logic [6:0] fifo_threshold = 7'h01, receive_fill_count = 7'h00, transmit_fill_count;
	logic [7:0] packet_length_setting = 8'h01, node_address = 8'h5a, rx_byte_in = 0, rssi_value = 8'h3c;
	logic [7:0] tx_fifo_data, tx_byte, rx_fifo_data, packet_state_flags, chip_status;
	logic [15:0] sync_word = 16'hd391;
	logic [2:0] radio_state;
	logic tx_fifo_pop, tx_byte_valid, tx_byte_ready, rx_fifo_write, rx_fifo_drop, rx_fifo_flush;
	logic general_output_zero, general_output_two, packet_done;
	logic [7:0] rxq[$];
	logic [7:0] addrs[4] = '{8'h5a, 8'h00, 8'hff, 8'h21};
	logic [7:0] txe[5] = '{rph_pkg::PREAMBLE_BYTE, 8'hd3, 8'h91, 8'hc1, 8'hc2};
	int err_total = 0, samples_checked = 0, drops = 0, dones = 0, cycles = 0, flushes = 0;
	radio_packet_handler dut (.clock, .rst_n, .length_mode, .packet_length_setting, .address_filter_mode,
		.node_address, .crc_enable, .crc_fail_flush_enable, .status_append_enable, .preamble_count, .sync_double,
		.sync_word, .receive_exit_state, .transmit_exit_state, .output_pin_function_zero, .output_pin_function_two,
		.fifo_threshold, .tx_strobe, .rx_strobe, .idle_strobe, .transmit_fifo_flush_strobe, .tx_fifo_data,
		.transmit_fill_count, .receive_fill_count, .tx_byte_ready, .rx_sync_found, .rx_byte_in, .rx_byte_valid,
		.rssi_value, .tx_fifo_pop, .tx_byte, .tx_byte_valid, .rx_fifo_write, .rx_fifo_data, .rx_fifo_drop,
		.rx_fifo_flush, .general_output_zero, .general_output_two, .packet_state_flags, .chip_status,
		.radio_state, .packet_done);
	rph_tx_partner p (.clock, .transmit_fifo_flush_strobe, .tx_fifo_pop, .tx_byte_valid, .tx_byte, .stall,
		.tx_fifo_data, .transmit_fill_count, .tx_byte_ready);
	////////////////////////
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (rx_fifo_write) rxq.push_back(rx_fifo_data);
		drops += rx_fifo_drop;
		flushes += rx_fifo_flush;
		dones += packet_done;
		if (cycles == 20000) begin
			err_total++;
			close_out();
		end
	end
	////////////////////////
	task automatic close_out;
		$display("checked %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic pulse(input int w);
		@(posedge clock) case (w) 0: tx_strobe <= 1; 1: idle_strobe <= 1; default: transmit_fifo_flush_strobe <= 1; endcase
		@(posedge clock) begin tx_strobe <= 0; idle_strobe <= 0; transmit_fifo_flush_strobe <= 0; end
	endtask
	// sw is the byte index at which fixed mode is switched in
	task automatic rx_pkt(input logic [7:0] b[], input int sw);
		rxq.delete();
		drops = 0;
		flushes = 0;
		dones = 0;
		@(posedge clock) rx_strobe <= 1;
		@(posedge clock) begin rx_strobe <= 0; rx_sync_found <= 1; end
		@(posedge clock) rx_sync_found <= 0;
		@(posedge clock);
		@(negedge clock) `CHK(general_output_zero, 1'b1)
		foreach (b[i]) begin
			@(posedge clock) begin rx_byte_valid <= 1; rx_byte_in <= b[i]; if (i == sw) length_mode <= 0; end
			@(posedge clock) rx_byte_valid <= 0;
		end
		tick(6);
		@(negedge clock);
	endtask
	task automatic chkq(input logic [7:0] e[]);
		`CHK(rxq.size(), e.size())
		foreach (e[i]) if (i < rxq.size()) `CHK(rxq[i], e[i])
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] d[]);
		crc16 = rph_pkg::CRC_INIT;
		foreach (d[i]) for (int b = 7; b >= 0; b--)
			crc16 = {crc16[14:0], 1'b0} ^ ((crc16[15] ^ d[i][b]) ? rph_pkg::CRC_POLY : 16'h0000);
	endfunction
	////////////////////////
	initial begin
		logic [7:0] a;
		logic [7:0] lb[];
		logic [15:0] c;
		bit ok;
		tick(2);
		rst_n <= 1;
		@(negedge clock) `CHK(radio_state, rph_pkg::RS_IDLE)
		@(posedge clock) status_append_enable <= 1;
		rx_pkt('{8'h11}, -1);
		chkq('{8'h11, 8'h3c, 8'h80});
		`CHK(dones, 1)
		`CHK(radio_state, rph_pkg::RS_IDLE)
		@(posedge clock) begin status_append_enable <= 0; packet_length_setting <= 8'h02; end
		for (int m = 0; m < 4; m++) for (int k = 0; k < 4; k++) begin
			a = addrs[k];
			ok = m == 0 || a == 8'h5a || (m > 1 && a == 8'h00) || (m == 3 && a == 8'hff);
			@(posedge clock) address_filter_mode <= m[1:0];
			rx_pkt('{a, 8'h22}, -1);
			if (ok) chkq('{a, 8'h22});
			else begin `CHK(drops, 1) `CHK(radio_state, rph_pkg::RS_RX) end
			pulse(1);
		end
		@(posedge clock) begin address_filter_mode <= 0; length_mode <= rph_pkg::LEN_VARIABLE; end
		rx_pkt('{8'h03, 8'h01, 8'h02, 8'h03}, -1);
		`CHK(rxq.size(), 0)
		`CHK(radio_state, rph_pkg::RS_RX)
		`CHK(chip_status, 8'h20)
		rx_pkt('{8'h02, 8'h44, 8'h55}, -1);
		chkq('{8'h02, 8'h44, 8'h55});
		@(posedge clock) begin address_filter_mode <= 1; length_mode <= rph_pkg::LEN_INFINITE; end
		rx_pkt('{8'h5a, 8'h33}, -1);
		chkq('{8'hff, 8'h5a, 8'h33});
		pulse(1);
		@(posedge clock) address_filter_mode <= 0;
		lb = new[258];
		foreach (lb[i]) lb[i] = i[7:0];
		rx_pkt(lb, 10); // length 258 sent as 2 with infinite start
		`CHK(rxq.size(), 258)
		`CHK(dones, 1)
		// transmit with a slow modem
		@(posedge clock) begin length_mode <= rph_pkg::LEN_FIXED; stall <= 1; crc_enable <= 1; end
		p.fifo.push_back(8'hc1);
		p.fifo.push_back(8'hc2);
		dones = 0;
		pulse(0);
		for (int k = 0; k < 80 && dones == 0; k++) @(posedge clock);
		@(negedge clock) `CHK(p.sent.size(), 7)
		foreach (txe[i]) `CHK(p.sent[i], txe[i])
		c = crc16('{8'hc1, 8'hc2});
		`CHK(p.sent[5], c[15:8])
		`CHK(p.sent[6], c[7:0])
		@(posedge clock) begin packet_length_setting <= 8'h03; length_mode <= rph_pkg::LEN_VARIABLE; end
		p.fifo.push_back(8'h03);
		p.fifo.push_back(8'hd1);
		pulse(0);
		tick(40);
		@(negedge clock) `CHK(radio_state, rph_pkg::RS_UFLOW)
		p.fifo.push_back(8'hd2);
		tick(10);
		// status read twice, both must agree
		@(negedge clock) `CHK(radio_state, rph_pkg::RS_UFLOW)
		`CHK(tx_byte_valid, 1'b0)
		`CHK(chip_status, 8'he1)
		`CHK(packet_state_flags, 8'h04)
		pulse(2);
		tick(2);
		@(negedge clock) `CHK(radio_state, rph_pkg::RS_IDLE)
		`CHK(general_output_two, 1'b0)
		@(posedge clock) begin status_append_enable <= 1; crc_fail_flush_enable <= 1; end
		@(posedge clock) length_mode <= rph_pkg::LEN_FIXED;
		// short packets, each read out before the next
		c = crc16('{8'h31, 8'h32, 8'h33});
		rx_pkt('{8'h31, 8'h32, 8'h33, c[15:8], c[7:0]}, -1);
		chkq('{8'h31, 8'h32, 8'h33, 8'h3c, 8'h80});
		@(posedge clock) receive_exit_state <= rph_pkg::EXIT_RX;
		rx_pkt('{8'h31, 8'h32, 8'h33, ~c[15:8], c[7:0]}, -1);
		`CHK(flushes, 1)
		`CHK(dones, 1)
		`CHK(radio_state, rph_pkg::RS_RX)
		@(posedge clock) begin receive_fill_count <= 7'h01; fifo_threshold <= 7'h02; end
		@(posedge clock) begin output_pin_function_zero <= rph_pkg::FN_RX_THR_END; end
		@(posedge clock) output_pin_function_two <= rph_pkg::FN_RX_THR;
		tick(2);
		@(negedge clock) `CHK({general_output_two, general_output_zero}, 2'b01)
		@(posedge clock) begin fifo_threshold <= 7'h01; output_pin_function_zero <= rph_pkg::FN_TX_FULL; end
		tick(2);
		@(negedge clock) `CHK({general_output_two, general_output_zero}, 2'b10)
		`CHK(packet_state_flags, 8'h04)
		`CHK(chip_status, 8'h21)
		close_out();
	end
endmodule
`default_nettype wire

// ==== test/rph_tx_partner.sv ====
// transmit fifo and modem model facing the packet handler
`timescale 1ns/1ps
`default_nettype none
module rph_tx_partner (
	input  wire logic       clock,
	input  wire logic       transmit_fifo_flush_strobe,
	input  wire logic       tx_fifo_pop,
	input  wire logic       tx_byte_valid,
	input  wire logic [7:0] tx_byte,
	input  wire logic       stall,
	output logic [7:0]      tx_fifo_data = 8'h00,
	output logic [6:0]      transmit_fill_count = 7'h00,
	output logic            tx_byte_ready = 1'b1
);
	logic [7:0] fifo[$];
	logic [7:0] sent[$];
	////////////////////////
	always @(posedge clock) begin
		if (transmit_fifo_flush_strobe) fifo.delete();
		else if (tx_fifo_pop && fifo.size() != 0) void'(fifo.pop_front());
		if (tx_byte_valid && tx_byte_ready) sent.push_back(tx_byte);
		tx_byte_ready <= !stall || !tx_byte_ready;
		// empty head toggles so a stale byte never passes as data
		transmit_fill_count <= 7'(fifo.size());
		tx_fifo_data <= fifo.size() != 0 ? fifo[0] : ~tx_fifo_data;
	end
endmodule
`default_nettype wire
